// ==== hw/ptv_pkg.sv ====
// Purpose: Constants for the PCI-to-VME window 1 decode block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Offsets are byte addresses
package ptv_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CONTROL = 12'h0114;
  localparam logic [11:0] OFS_BASE    = 12'h0118;
  localparam logic [11:0] OFS_BOUND   = 12'h011c;
  localparam logic [11:0] OFS_XLATE   = 12'h0120;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE   = 31;
  localparam int BIT_POSTED   = 30;
  localparam int WID_HI       = 23;
  localparam int WID_LO       = 22;
  localparam int SPC_HI       = 18;
  localparam int SPC_LO       = 16;
  localparam int BIT_PROGRAM  = 14;
  localparam int BIT_SUPER    = 12;
  localparam int BIT_BLOCK    = 8;
  localparam int BIT_IOSPACE  = 0;
  localparam int WIN_LSB      = 16;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_D8   = 2'h0;
  localparam logic [1:0] WIDTH_D16  = 2'h1;
  localparam logic [1:0] WIDTH_D32  = 2'h2;
  localparam logic [1:0] WIDTH_D64  = 2'h3;
  localparam logic [1:0] WIDTH_RST  = 2'h2;
  localparam logic [2:0] SPACE_A16  = 3'h0;
  localparam logic [2:0] SPACE_A24  = 3'h1;
  localparam logic [2:0] SPACE_A32  = 3'h2;
  localparam logic [2:0] SPACE_CSR  = 3'h5;
  localparam logic [2:0] SPACE_USR1 = 3'h6;
  localparam logic [2:0] SPACE_USR2 = 3'h7;
  localparam logic [15:0] WIN_RST   = 16'h0000;

endpackage : ptv_pkg

// ==== hw/ptv_cmp.sv ====
// Purpose: Window hit and address translation datapath
// Assumes: Upper 16 address bits only, 64 Kbyte granularity
// Notes:   Purely combinational
`timescale 1ns/1ns
module ptv_cmp #(
  parameter int AW = 16
) (
  // Programmed window
  input  wire logic [AW-1:0] baseHi,
  input  wire logic [AW-1:0] boundHi,
  input  wire logic [AW-1:0] offsetHi,
  // Incoming address
  input  wire logic [AW-1:0] addrHi,
  // Results
  output logic             inRange,
  output logic [AW-1:0]    xlatHi
);

  // ----------------------------------------------------------------
  // Compare and add
  // ----------------------------------------------------------------
  logic aboveBase;  // At or above base
  logic belowBound; // Strictly below bound, or no bound
  assign aboveBase  = addrHi >= baseHi;
  assign belowBound = (boundHi == '0) || (addrHi < boundHi);
  assign inRange    = aboveBase && belowBound;
  // Carry out is dropped on purpose: wraps modulo 4 Gbyte
  assign xlatHi     = addrHi + offsetHi;

endmodule : ptv_cmp

// ==== hw/ptv_window1.sv ====
// Purpose: APB registers and decode for PCI-to-VME window 1
// Assumes: PCI address presented synchronous to clk_sys
// Notes:   Zero-wait APB slave; unmapped reads give zero, pslverr
//
// Summary of operation
// - Block select only for A24/A32 narrow widths
// - A24/A32 64-bit may use multiplexed block
// - I/O space forces coupled, ignores posting
// - Width field 23:22, reset 32-bit
// - Space field 18:16, two codes reserved
// - Bit 14 selects program or data
// - Bit 12 selects supervisor or user
// - Bit 8 allows single block transfers
// - Bit 0 selects PCI I/O space
// - Base is lowest decoded address
// - Claim when base <= addr < bound
// - Zero bound means no upper limit
// - 64 Kbyte granularity, low bits read zero
// - VME upper bits = PCI plus offset
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module ptv_window1 #(
  parameter int AW = 32
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // PCI side address
  input  wire logic [AW-1:0] pciAddr,
  input  wire logic          pciValid,
  // Decode results toward the VME engine
  output logic               windowHit,
  output logic [AW-1:0]      vmeAddr,
  output logic [2:0]         vmeSpace,
  output logic [1:0]         vmeWidth,
  output logic               amProgram,
  output logic               amSuper,
  output logic               singleBlockOk,
  output logic               multiBlockOk,
  output logic               postWrites,
  output logic               spaceReserved
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (AW != 32) begin : g_badAw
    $error("ptv_window1 serves only a 32-bit address");
  end

  // ----------------------------------------------------------------
  // Control and window registers
  // ----------------------------------------------------------------
  logic        enable_r;     // Window enable
  logic        posted_r;     // Posted write allow
  logic [1:0]  width_r;      // Max VME data width
  logic [2:0]  space_r;      // VME address space
  logic        program_r;    // Program/data select
  logic        super_r;      // Privilege select
  logic        block_r;      // Block transfer select
  logic        ioSpace_r;    // PCI space select
  logic [15:0] base_r;       // Base, bits 31:16
  logic [15:0] bound_r;      // Bound, bits 31:16
  logic [15:0] offset_r;     // Offset, bits 31:16

  logic        wrStrobe;     // Write takes effect this edge
  logic        mapped;       // Address decodes to a register
  logic [31:0] ctlWord;      // Control register read image

  // Access phase with pready high; slave never waits
  assign pready   = 1'b1;
  assign wrStrobe = psel && penable && pwrite;
  assign mapped   = (paddr == ptv_pkg::OFS_CONTROL) ||
                    (paddr == ptv_pkg::OFS_BASE)    ||
                    (paddr == ptv_pkg::OFS_BOUND)   ||
                    (paddr == ptv_pkg::OFS_XLATE);
  // Unmapped access answers with an error, no state change
  assign pslverr  = psel && penable && !mapped;

  // Control register; enable, space and I/O select reset to zero
  // though undefined, so the window starts closed and safe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_r  <= 1'b0;
      posted_r  <= 1'b0;
      width_r   <= ptv_pkg::WIDTH_RST;
      space_r   <= ptv_pkg::SPACE_A16;
      program_r <= 1'b0;
      super_r   <= 1'b0;
      block_r   <= 1'b0;
      ioSpace_r <= 1'b0;
    end else if (wrStrobe && paddr == ptv_pkg::OFS_CONTROL) begin
      enable_r  <= pwdata[ptv_pkg::BIT_ENABLE];
      posted_r  <= pwdata[ptv_pkg::BIT_POSTED];
      width_r   <= pwdata[ptv_pkg::WID_HI:ptv_pkg::WID_LO];
      space_r   <= pwdata[ptv_pkg::SPC_HI:ptv_pkg::SPC_LO];
      program_r <= pwdata[ptv_pkg::BIT_PROGRAM];
      super_r   <= pwdata[ptv_pkg::BIT_SUPER];
      block_r   <= pwdata[ptv_pkg::BIT_BLOCK];
      ioSpace_r <= pwdata[ptv_pkg::BIT_IOSPACE];
    end
  end

  // Window registers; only the upper half is stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_r   <= ptv_pkg::WIN_RST;
      bound_r  <= ptv_pkg::WIN_RST;
      offset_r <= ptv_pkg::WIN_RST;
    end else if (wrStrobe) begin
      if (paddr == ptv_pkg::OFS_BASE) begin
        base_r <= pwdata[31:ptv_pkg::WIN_LSB];
      end
      if (paddr == ptv_pkg::OFS_BOUND) begin
        bound_r <= pwdata[31:ptv_pkg::WIN_LSB];
      end
      if (paddr == ptv_pkg::OFS_XLATE) begin
        offset_r <= pwdata[31:ptv_pkg::WIN_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved control bits read as zero
  always_comb begin
    ctlWord = 32'h0000_0000;
    ctlWord[ptv_pkg::BIT_ENABLE]                = enable_r;
    ctlWord[ptv_pkg::BIT_POSTED]                = posted_r;
    ctlWord[ptv_pkg::WID_HI:ptv_pkg::WID_LO]    = width_r;
    ctlWord[ptv_pkg::SPC_HI:ptv_pkg::SPC_LO]    = space_r;
    ctlWord[ptv_pkg::BIT_PROGRAM]               = program_r;
    ctlWord[ptv_pkg::BIT_SUPER]                 = super_r;
    ctlWord[ptv_pkg::BIT_BLOCK]                 = block_r;
    ctlWord[ptv_pkg::BIT_IOSPACE]               = ioSpace_r;
  end

  // Read data is registered in the setup cycle, valid in access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ptv_pkg::OFS_CONTROL: prdata <= ctlWord;
        ptv_pkg::OFS_BASE:    prdata <= {base_r, 16'h0000};
        ptv_pkg::OFS_BOUND:   prdata <= {bound_r, 16'h0000};
        ptv_pkg::OFS_XLATE:   prdata <= {offset_r, 16'h0000};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decode datapath
  // ----------------------------------------------------------------
  logic        inRange;  // Address inside base/bound
  logic [15:0] xlatHi;   // Translated upper address

  ptv_cmp #(
    .AW (16)
  ) u_cmp (
    .baseHi   (base_r),
    .boundHi  (bound_r),
    .offsetHi (offset_r),
    .addrHi   (pciAddr[31:16]),
    .inRange  (inRange),
    .xlatHi   (xlatHi)
  );

  // ----------------------------------------------------------------
  // Attribute decode
  // ----------------------------------------------------------------
  logic wideSpace;  // A24 or A32 selected
  assign wideSpace = (space_r == ptv_pkg::SPACE_A24) ||
                     (space_r == ptv_pkg::SPACE_A32);

  // Registered results so the VME engine sees clean flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      windowHit     <= 1'b0;
      vmeAddr       <= '0;
      vmeSpace      <= ptv_pkg::SPACE_A16;
      vmeWidth      <= ptv_pkg::WIDTH_RST;
      amProgram     <= 1'b0;
      amSuper       <= 1'b0;
      singleBlockOk <= 1'b0;
      multiBlockOk  <= 1'b0;
      postWrites    <= 1'b0;
      spaceReserved <= 1'b0;
    end else begin
      windowHit     <= pciValid && enable_r && inRange;
      vmeAddr       <= {xlatHi, pciAddr[15:0]};
      vmeSpace      <= space_r;
      vmeWidth      <= width_r;
      amProgram     <= program_r;
      amSuper       <= super_r;
      // Block select only counts for narrow widths in A24/A32
      singleBlockOk <= block_r && wideSpace &&
                       (width_r != ptv_pkg::WIDTH_D64);
      // 64-bit in A24/A32 may go multiplexed regardless
      multiBlockOk  <= wideSpace &&
                       (width_r == ptv_pkg::WIDTH_D64);
      // I/O space window is always coupled
      postWrites    <= posted_r && !ioSpace_r;
      spaceReserved <= (space_r == 3'h3) ||
                       (space_r == 3'h4);
    end
  end

endmodule : ptv_window1

// ==== sim/ptv_window1_sva.sv ====
// Purpose: Checker for window 1 decode outputs
// Assumes: Shadow registers follow APB writes
// Notes:   Decode outputs lag their cause by one edge
`timescale 1ns/1ns
module ptv_window1_chk (
  // Clock, reset and APB
  input wire logic        clk_sys, rst, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata, pciAddr, vmeAddr,
  // Decode results
  input wire logic        pciValid, windowHit, amProgram, amSuper,
  input wire logic        singleBlockOk, multiBlockOk, postWrites,
  input wire logic        spaceReserved,
  input wire logic [2:0]  vmeSpace,
  input wire logic [1:0]  vmeWidth
);
  logic [31:0] ctlR;            // Shadow of the control word
  logic [15:0] bsR, bdR, toR;   // Shadows of the stored upper halves
  wire wr = psel && penable && pwrite && pready;
  wire a2432 = ctlR[18:16] == 3'h1 || ctlR[18:16] == 3'h2;
  wire hitC = pciValid && ctlR[31] && pciAddr[31:16] >= bsR &&
              (bdR == 16'h0000 || pciAddr[31:16] < bdR);
  wire [31:0] xl = {pciAddr[31:16] + toR, pciAddr[15:0]};
  // Shadows land on the same edge as the design's own registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctlR <= 32'h0080_0000;
      bsR  <= 16'h0000;
      bdR  <= 16'h0000;
      toR  <= 16'h0000;
    end else if (wr) begin
      if (paddr == ptv_pkg::OFS_CONTROL) ctlR <= pwdata;
      if (paddr == ptv_pkg::OFS_BASE) bsR <= pwdata[31:16];
      if (paddr == ptv_pkg::OFS_BOUND) bdR <= pwdata[31:16];
      if (paddr == ptv_pkg::OFS_XLATE) toR <= pwdata[31:16];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_width; vmeWidth == $past(ctlR[23:22]); endproperty
  a_width: assert property (p_width) else $error("width");
  property p_space; {spaceReserved, vmeSpace} == $past({ctlR[18:16]
    inside {3'h3, 3'h4}, ctlR[18:16]}); endproperty
  a_space: assert property (p_space) else $error("space");
  property p_am; {amProgram, amSuper} == $past({ctlR[14], ctlR[12]});
  endproperty
  a_am: assert property (p_am) else $error("am");
  property p_post; postWrites == $past(ctlR[30] && !ctlR[0]); endproperty
  a_post: assert property (p_post) else $error("post");
  property p_sb; singleBlockOk == $past(ctlR[8] && a2432 &&
    ctlR[23:22] != 2'h3); endproperty
  a_sb: assert property (p_sb) else $error("single");
  property p_mb; multiBlockOk == $past(a2432 && ctlR[23:22] == 2'h3);
  endproperty
  a_mb: assert property (p_mb) else $error("multi");
  property p_hit; windowHit == $past(hitC); endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_xl; windowHit |-> vmeAddr == $past(xl); endproperty
  a_xl: assert property (p_xl) else $error("xlate");
  property p_rd; psel && penable && !pwrite &&
    paddr == ptv_pkg::OFS_BASE |-> prdata == {bsR, 16'h0000}; endproperty
  a_rd: assert property (p_rd) else $error("base read");
  c_hit: cover property (windowHit);
  c_mb: cover property (multiBlockOk);
  c_res: cover property (spaceReserved);
endmodule : ptv_window1_chk

bind ptv_window1 ptv_window1_chk i_ptv_window1_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pciAddr(pciAddr), .vmeAddr(vmeAddr),
  .pciValid(pciValid), .windowHit(windowHit), .amProgram(amProgram),
  .amSuper(amSuper), .singleBlockOk(singleBlockOk),
  .multiBlockOk(multiBlockOk), .postWrites(postWrites),
  .spaceReserved(spaceReserved), .vmeSpace(vmeSpace),
  .vmeWidth(vmeWidth));

// ==== sim/ptv_pci_master.sv ====
// Purpose: PCI-side address source for window 1
// Assumes: One address per cycle while req is high
// Notes:   Released bus toggles so stale addresses never look valid
`timescale 1ns/1ns
module ptv_pci_master (
  // Clock, reset and request
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [31:0] reqAddr,
  // PCI address toward the block
  output logic             pciValid,
  output logic [31:0]      pciAddr
);
  // Launch one cycle after the request, like a real address phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pciValid <= 1'b0;
      pciAddr  <= 32'h0000_0000;
    end else begin
      pciValid <= req;
      pciAddr  <= req ? reqAddr : ~pciAddr;
    end
  end
endmodule : ptv_pci_master

// ==== sim/ptv_window1_tb.sv ====
// Purpose: Self-checking bench for window 1 decode
// Assumes: Zero-wait APB slave, decode one edge after sample
// Notes:   Expectations are queued by the drivers
`timescale 1ns/1ns
module ptv_window1_tb;
  logic        clk_sys, rst, psel, penable, pwrite, req, vldD;
  logic        pready, pslverr, pciValid, windowHit;
  logic [11:0] paddr;
  logic [31:0] pwdata, reqAddr, seed, ctlV, pciAddr, prdata, vmeAddr;
  logic [15:0] bsV, bdV, toV;   // Bench copy of the programmed window
  logic [32:0] rdQ[$];          // Expected {pslverr, prdata}
  logic [32:0] hitQ[$];         // Expected {windowHit, vmeAddr}
  int          failures, compares, cyc;
  // Decode as seen; the address only counts on a hit
  wire  [32:0] hitSeen = {windowHit, windowHit ? vmeAddr : 32'h0};
  ptv_window1 #(.AW(32)) i_ptv_window1 (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pciAddr(pciAddr), .pciValid(pciValid), .windowHit(windowHit),
    .vmeAddr(vmeAddr), .vmeSpace(), .vmeWidth(), .amProgram(),
    .amSuper(), .singleBlockOk(), .multiBlockOk(), .postWrites(),
    .spaceReserved());
  ptv_pci_master i_ptv_pci_master (.clk_sys(clk_sys), .rst(rst),
    .req(req), .reqAddr(reqAddr), .pciValid(pciValid), .pciAddr(pciAddr));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [32:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic close_out();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // One APB transfer; a read queues its expected data and error flag
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    if (!w) rdQ.push_back({!(a inside {ptv_pkg::OFS_CONTROL,
      ptv_pkg::OFS_BASE, ptv_pkg::OFS_BOUND, ptv_pkg::OFS_XLATE}), d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // Present one PCI address and queue the decode it should give
  task automatic pci(input logic [31:0] a);
    logic h;
    h = ctlV[31] && a[31:16] >= bsV && (bdV == 16'h0 || a[31:16] < bdV);
    hitQ.push_back({h, h ? {a[31:16] + toV, a[15:0]} : 32'h0});
    req <= 1'b1;
    reqAddr <= a;
    @(posedge clk_sys);
  endtask : pci
  // Watch results as they appear; also cut a hang short
  always @(posedge clk_sys) begin
    vldD <= pciValid;
    cyc++;
    if (psel && penable && pready && !pwrite)
      chk("apb read", {pslverr, prdata}, rdQ.pop_front());
    if (vldD) chk("decode", hitSeen, hitQ.pop_front());
    if (cyc > 20000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, req} = 5'b10000;
    {paddr, pwdata, reqAddr, ctlV} = '0;
    {bsV, bdV, toV} = '0;
    seed = 32'h5f6f_01d6;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, ptv_pkg::OFS_CONTROL, 32'h0080_0000);
    apb(1'b0, ptv_pkg::OFS_BOUND, 32'h0);
    apb(1'b1, 12'h124, 32'hffff_ffff);
    apb(1'b0, 12'h124, 32'h0);
    // Every space and width code, window off first, bound zero once;
    // width is mixed from three index bits so A32 meets 64-bit once
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      bsV = {1'b0, seed[30:16]};
      bdV = (i == 3) ? 16'h0 : bsV + 16'h0010;
      toV = seed[15:0];
      ctlV = (seed & 32'h4000_5101) |
             {i != 0, 7'h0, i[1:0] ^ i[2:1], 3'h0, i[2:0],
              16'h0};
      apb(1'b1, ptv_pkg::OFS_CONTROL, ctlV);
      apb(1'b1, ptv_pkg::OFS_BASE, {bsV, seed[15:0]});
      apb(1'b1, ptv_pkg::OFS_BOUND, {bdV, 16'hffff});
      apb(1'b1, ptv_pkg::OFS_XLATE, {toV, ~seed[15:0]});
      apb(1'b0, ptv_pkg::OFS_CONTROL, ctlV);
      apb(1'b0, ptv_pkg::OFS_BASE, {bsV, 16'h0});
      apb(1'b0, ptv_pkg::OFS_XLATE, {toV, 16'h0});
      pci({bsV, seed[15:0]});
      pci({bsV - 16'h1, 16'hffff});
      pci({bdV - 16'h1, 16'hffff});
      pci({bdV, 16'h0});
      pci(lfsr(seed));
      req <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    close_out();
  end
endmodule : ptv_window1_tb
